// *** hw/hspl_top.sv ***
// Homing sequencer and position latch with AHB-Lite registers
//
// Local design decisions: the register offsets and register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
module hspl_top
(
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata_ff,
  output logic             hreadyout_ff,
  output logic             hresp_ff,
  // Switches, index and trigger inputs
  input  wire logic [7:0]  home_raw,
  input  wire logic [7:0]  index_raw,
  input  wire logic [7:0]  fb_home,
  input  wire logic [7:0]  fb_index,
  input  wire logic [11:0] gp_in,
  // Encoder positions
  input  wire logic [7:0][31:0] main_pos,
  input  wire logic [7:0][31:0] aux_pos,
  // Motion profiler
  input  wire logic        prof_stopped,
  input  wire logic        prof_at_target,
  output logic [2:0]       prof_axis_ff,
  output logic             prof_move_ff,
  output logic             prof_dir_ff,
  output logic [31:0]      prof_speed_ff,
  output logic             prof_halt_ff,
  output logic             prof_goto_ff,
  output logic [31:0]      prof_target_ff,
  output logic             enc_load_ff,
  output logic [31:0]      enc_load_val_ff
);
  import hspl_pkg::*;

  // ==========================================================
  // Register state
  logic [7:0]  pol_ff;
  logic [23:0] capcfg_ff;
  logic [31:0] slew_ff;
  logic [31:0] hvel_ff;
  logic        wr_pend_ff;
  logic [7:0]  wr_addr_ff;
  logic        done_ff;
  logic [7:0]  home_state;
  logic [7:0]  idx_state;
  logic [7:0]  arm_pulse;
  logic [7:0]  cap_flag;
  logic [7:0]  cap_armed;
  logic [31:0] cap_val [8];
  logic        start;
  logic [1:0]  start_cmd;

  // ==========================================================
  // Sequencer state
  hspl_state_type st_ff;
  logic [1:0]  cmd_ff;
  logic        dir1_ff;
  logic        ref_ff;
  logic        idx_prev_ff;
  logic [31:0] idx_pos_ff;
  logic        home_cur;
  logic        idx_cur;
  logic [31:0] pos_cur;
  logic        start_level;

  // Per axis input selection and capture units
  genvar a;
  generate
    for (a = 0; a < 8; a++)
    begin : g_axis
      localparam int TI = (a < 4) ? a : a + 4;
      logic hsrc;
      assign hsrc = capcfg_ff[CFG_FB_LSB + a] ? fb_home[a] : home_raw[a];
      // Polarity 0 passes the pin, 1 inverts it
      assign home_state[a] = pol_ff[a] ? ~hsrc : hsrc;
      assign idx_state[a] = capcfg_ff[CFG_FB_LSB + a] ? fb_index[a]
                                                       : index_raw[a];
      hspl_capture u_cap
      (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .trig_in   (gp_in[TI]),
        .index_in  (idx_state[a]),
        .src_index (capcfg_ff[CFG_IDX_LSB + a]),
        .src_aux   (capcfg_ff[CFG_AUX_LSB + a]),
        .main_pos  (main_pos[a]),
        .aux_pos   (aux_pos[a]),
        .arm       (arm_pulse[a]),
        .armed_ff  (cap_armed[a]),
        .flag_ff   (cap_flag[a]),
        .value_ff  (cap_val[a])
      );
    end
  endgenerate

  // Register read decode
  function automatic logic [31:0] rd_mux(input logic [7:0] ad);
    rd_mux = 32'h0000_0000;
    if (ad == CTRL_OFS)
      rd_mux = {26'h0, cmd_ff, 1'b0, prof_axis_ff};
    else if (ad == STAT_OFS)
      rd_mux = {cap_armed, cap_flag, home_state, 6'h00, done_ff,
                (st_ff != ST_IDLE)};
    else if (ad == POL_OFS)
      rd_mux = {24'h0, pol_ff};
    else if (ad == CAPCFG_OFS)
      rd_mux = {8'h00, capcfg_ff};
    else if (ad == SLEW_OFS)
      rd_mux = slew_ff;
    else if (ad == HVEL_OFS)
      rd_mux = hvel_ff;
    else if (ad[7:5] == CAPPOS_PAGE)
      rd_mux = cap_val[ad[4:2]];
  endfunction

  // ==========================================================
  // AHB-Lite slave: zero wait, always OKAY
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hreadyout_ff <= 1'b1;
      hresp_ff     <= 1'b0;
      hrdata_ff    <= 32'h0000_0000;
      wr_pend_ff   <= 1'b0;
      wr_addr_ff   <= 8'h00;
    end
    else
    begin
      wr_pend_ff <= hsel & hready & htrans[1] & hwrite;
      wr_addr_ff <= haddr[7:0];
      if (hsel && hready && htrans[1] && !hwrite)
        hrdata_ff <= rd_mux(haddr[7:0]);
    end
  end

  // Write strobes decoded in the data phase
  assign start     = wr_pend_ff && (wr_addr_ff == CTRL_OFS) && (st_ff == ST_IDLE);
  assign start_cmd = hwdata[CTRL_CMD_LSB +: 2];
  assign arm_pulse = (wr_pend_ff && wr_addr_ff == ARM_OFS) ? hwdata[7:0] : 8'h00;

  // Configuration registers
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pol_ff    <= POL_RST;
      capcfg_ff <= 24'h00_0000;
      slew_ff   <= SLEW_RST;
      hvel_ff   <= HVEL_RST;
    end
    else if (wr_pend_ff)
    begin
      if (wr_addr_ff == POL_OFS)
        pol_ff <= hwdata[7:0];
      else if (wr_addr_ff == CAPCFG_OFS)
        capcfg_ff <= hwdata[23:0];
      else if (wr_addr_ff == SLEW_OFS)
        slew_ff <= hwdata;
      else if (wr_addr_ff == HVEL_OFS)
        hvel_ff <= hwdata;
    end
  end

  // ==========================================================
  // Homing sequencer
  assign home_cur = home_state[prof_axis_ff];
  assign idx_cur  = idx_state[prof_axis_ff];
  assign pos_cur  = main_pos[prof_axis_ff];
  // Home level of the axis named in the command word
  assign start_level = home_state[hwdata[CTRL_AXIS_LSB +: 3]];

  // Index edge history
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      idx_prev_ff <= 1'b0;
    else
      idx_prev_ff <= idx_cur;
  end

  // Stage progression and profiler commands
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st_ff           <= ST_IDLE;
      cmd_ff          <= 2'h0;
      dir1_ff         <= 1'b0;
      ref_ff          <= 1'b0;
      done_ff         <= 1'b0;
      idx_pos_ff      <= 32'h0000_0000;
      prof_axis_ff    <= 3'h0;
      prof_move_ff    <= 1'b0;
      prof_dir_ff     <= 1'b0;
      prof_speed_ff   <= 32'h0000_0000;
      prof_halt_ff    <= 1'b0;
      prof_goto_ff    <= 1'b0;
      prof_target_ff  <= 32'h0000_0000;
      enc_load_ff     <= 1'b0;
      enc_load_val_ff <= 32'h0000_0000;
    end
    else
    begin
      prof_halt_ff <= 1'b0;
      enc_load_ff  <= 1'b0;
      case (st_ff)
        ST_IDLE:
          if (start && start_cmd != 2'h0)
          begin
            cmd_ff       <= start_cmd;
            done_ff      <= 1'b0;
            prof_axis_ff <= hwdata[CTRL_AXIS_LSB +: 3];
            if (start_cmd == CMD_INDEX)
            begin
              st_ff         <= ST_S3_RUN;
              prof_move_ff  <= 1'b1;
              prof_dir_ff   <= 1'b0;
              prof_speed_ff <= hvel_ff;
            end
            else
            begin
              // Start level picks the way: 1 reverse, 0 forward
              st_ff         <= ST_S1_RUN;
              dir1_ff       <= home_state[hwdata[CTRL_AXIS_LSB +: 3]];
              ref_ff        <= home_state[hwdata[CTRL_AXIS_LSB +: 3]];
              prof_dir_ff   <= home_state[hwdata[CTRL_AXIS_LSB +: 3]];
              prof_move_ff  <= 1'b1;
              prof_speed_ff <= slew_ff;
            end
          end
        ST_S1_RUN:
          if (home_cur != ref_ff)
          begin
            st_ff        <= ST_S1_STOP;
            prof_move_ff <= 1'b0;
          end
        ST_S1_STOP:
          if (prof_stopped)
          begin
            if (cmd_ff == CMD_EDGE)
            begin
              st_ff   <= ST_IDLE;
              done_ff <= 1'b1;
            end
            else
            begin
              st_ff         <= ST_S2_RUN;
              prof_move_ff  <= 1'b1;
              prof_dir_ff   <= ~dir1_ff;
              prof_speed_ff <= hvel_ff;
            end
          end
        ST_S2_RUN:
          if (home_cur == ref_ff)
          begin
            if (dir1_ff)
              st_ff <= ST_S3_RUN;
            else
            begin
              st_ff        <= ST_S2_HALT;
              prof_move_ff <= 1'b0;
              prof_halt_ff <= 1'b1;
            end
          end
        ST_S2_HALT:
          if (prof_stopped && !prof_halt_ff)
          begin
            st_ff        <= ST_S3_RUN;
            prof_move_ff <= 1'b1;
            prof_dir_ff  <= 1'b0;
          end
        ST_S3_RUN:
          if (idx_cur && !idx_prev_ff)
          begin
            st_ff        <= ST_S3_STOP;
            idx_pos_ff   <= pos_cur;
            prof_move_ff <= 1'b0;
          end
        ST_S3_STOP:
          if (prof_stopped)
          begin
            st_ff          <= ST_S3_BACK;
            prof_goto_ff   <= 1'b1;
            prof_target_ff <= idx_pos_ff;
          end
        ST_S3_BACK:
          if (prof_at_target && prof_stopped)
          begin
            st_ff           <= ST_ZERO;
            prof_goto_ff    <= 1'b0;
            enc_load_ff     <= 1'b1;
            enc_load_val_ff <= pos_cur - idx_pos_ff;
          end
        ST_ZERO:
          begin
            st_ff   <= ST_IDLE;
            done_ff <= 1'b1;
          end
        default:
          st_ff <= ST_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Checks
  a_stage1_dir: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_ff == ST_IDLE && start && start_cmd[0])
      |=> (prof_dir_ff == $past(start_level)))
    else $error("stage one direction does not follow home level");
  a_stage1_speed: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_ff == ST_S1_RUN) |-> (prof_move_ff && prof_speed_ff == slew_ff))
    else $error("stage one not at slew speed");
  a_stage1_brake: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_ff == ST_S1_RUN && home_cur != ref_ff) |=> !prof_move_ff)
    else $error("stage one did not brake on home change");
  a_stage2_move: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_ff == ST_S2_RUN) |-> (prof_dir_ff != dir1_ff && prof_speed_ff == hvel_ff))
    else $error("stage two direction or speed wrong");
  a_smooth_join: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_ff == ST_S2_RUN && home_cur == ref_ff && dir1_ff)
      |=> (prof_move_ff && !prof_halt_ff && st_ff == ST_S3_RUN))
    else $error("stage two to three did not continue smoothly");
  a_done_zeroed: assert property (@(posedge hclk) disable iff (!hresetn)
    ($rose(done_ff) && cmd_ff != CMD_EDGE) |-> $past(enc_load_ff))
    else $error("home reported done before zeroing");
endmodule // hspl_top
`default_nettype wire

// *** hw/hspl_pkg.sv ***
// Shared constants for the homing sequencer and position latch
package hspl_pkg;
  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] CTRL_OFS    = 8'h00;
  localparam logic [7:0] STAT_OFS    = 8'h04;
  localparam logic [7:0] POL_OFS     = 8'h08;
  localparam logic [7:0] CAPCFG_OFS  = 8'h0C;
  localparam logic [7:0] SLEW_OFS    = 8'h10;
  localparam logic [7:0] HVEL_OFS    = 8'h14;
  localparam logic [7:0] ARM_OFS     = 8'h18;
  localparam logic [2:0] CAPPOS_PAGE = 3'h1;
  // ==========================================================
  // Field positions
  localparam int CTRL_AXIS_LSB  = 0;
  localparam int CTRL_CMD_LSB   = 4;
  localparam int CFG_IDX_LSB    = 0;
  localparam int CFG_AUX_LSB    = 8;
  localparam int CFG_FB_LSB     = 16;
  localparam int STAT_HOME_LSB  = 8;
  localparam int STAT_FLAG_LSB  = 16;
  localparam int STAT_ARMED_LSB = 24;
  // ==========================================================
  // Reset values
  localparam logic [7:0]  POL_RST  = 8'h00;
  localparam logic [31:0] SLEW_RST = 32'h0000_0000;
  localparam logic [31:0] HVEL_RST = 32'h0000_0000;
  // ==========================================================
  // Homing commands and sequencer states
  localparam logic [1:0] CMD_EDGE  = 2'h1;
  localparam logic [1:0] CMD_INDEX = 2'h2;
  localparam logic [1:0] CMD_HOME  = 2'h3;
  typedef enum logic [3:0] {
    ST_IDLE, ST_S1_RUN, ST_S1_STOP, ST_S2_RUN, ST_S2_HALT,
    ST_S3_RUN, ST_S3_STOP, ST_S3_BACK, ST_ZERO
  } hspl_state_type;
  // ==========================================================
  // Capture latency bound
  localparam int CLK_PERIOD_NS  = 25;
  localparam int CAP_LIMIT_NS   = 25000;
  localparam int CAP_LIMIT_CYC  = CAP_LIMIT_NS / CLK_PERIOD_NS;
endpackage

// *** hw/hspl_capture.sv ***
// One axis of the high speed position latch
`timescale 1ns/1ps
`default_nettype none
module hspl_capture
(
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // Trigger sources
  input  wire logic        trig_in,
  input  wire logic        index_in,
  input  wire logic        src_index,
  input  wire logic        src_aux,
  // Encoder positions
  input  wire logic [31:0] main_pos,
  input  wire logic [31:0] aux_pos,
  // Software control
  input  wire logic        arm,
  output logic             armed_ff,
  output logic             flag_ff,
  output logic [31:0]      value_ff
);
  import hspl_pkg::*;

  logic        src;
  logic        prev_ff;
  logic        fall;
  logic [31:0] sel_pos;

  // Trigger and encoder choice
  assign src     = src_index ? index_in : trig_in;
  assign sel_pos = src_aux ? aux_pos : main_pos;
  assign fall    = prev_ff & ~src;

  // Previous trigger level
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      prev_ff <= 1'b0;
    else
      prev_ff <= src;
  end

  // Arm, fire once, then disarm; a capture beats a re-arm in the same cycle
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      armed_ff <= 1'b0;
      flag_ff  <= 1'b0;
      value_ff <= 32'h0000_0000;
    end
    else if (armed_ff && fall)
    begin
      armed_ff <= 1'b0;
      flag_ff  <= 1'b1;
      value_ff <= sel_pos;
    end
    else if (arm)
    begin
      armed_ff <= 1'b1;
      flag_ff  <= 1'b0;
    end
  end

  a_cap_fall: assert property (@(posedge hclk) disable iff (!hresetn)
    (armed_ff && fall) |=> (flag_ff && value_ff == $past(sel_pos)))
    else $error("capture missed a falling edge");
  a_cap_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    (flag_ff && !arm) |=> ($stable(value_ff) && !armed_ff))
    else $error("captured value changed before re-arm");
  a_rearm_clr: assert property (@(posedge hclk) disable iff (!hresetn)
    (arm && !(armed_ff && fall)) |=> (!flag_ff && armed_ff))
    else $error("re-arm did not clear the flag");
endmodule // hspl_capture
`default_nettype wire

// *** test/hspl_axis_model.sv ***
// Behavioural model of one motor axis: encoder, home switch and index
`timescale 1ns/1ps
`default_nettype none
module hspl_axis_model
#(
  parameter logic [31:0] SWITCH_AT = 32'h0000_0064,
  parameter int          DECEL_CYC = 3
)
(
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // Bench control of the position
  input  wire logic        preset_en,
  input  wire logic [31:0] preset_val,
  // Profiler commands
  input  wire logic        prof_move,
  input  wire logic        prof_dir,
  input  wire logic        prof_halt,
  input  wire logic        prof_goto,
  input  wire logic [31:0] prof_target,
  input  wire logic        enc_load,
  input  wire logic [31:0] enc_load_val,
  // Sensors and status
  output logic [7:0]       home_raw,
  output logic [7:0]       index_raw,
  output logic [7:0][31:0] main_pos,
  output logic [7:0][31:0] aux_pos,
  output logic             prof_stopped,
  output logic             prof_at_target
);
  logic [31:0] pos_ff;
  logic        dir_ff;
  int          coast_ff;
  // ==========================================================
  // Motion: one count a cycle, coasting a few counts after release
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pos_ff   <= 32'h0000_0000;
      dir_ff   <= 1'b0;
      coast_ff <= 0;
    end
    else if (preset_en)
      pos_ff <= preset_val;
    else if (enc_load)
      pos_ff <= enc_load_val;   // Encoder takes the count handed over
    else if (prof_halt)
      coast_ff <= 0;
    else if (prof_move)
    begin
      dir_ff   <= prof_dir;
      coast_ff <= DECEL_CYC;
      pos_ff   <= prof_dir ? pos_ff - 32'h1 : pos_ff + 32'h1;
    end
    else if (coast_ff > 0)
    begin
      coast_ff <= coast_ff - 1;
      pos_ff   <= dir_ff ? pos_ff - 32'h1 : pos_ff + 32'h1;
    end
    else if (prof_goto && pos_ff != prof_target)
      pos_ff <= (pos_ff > prof_target) ? pos_ff - 32'h1 : pos_ff + 32'h1;
  end
  // Sensors: switch open above the edge, index every 64 counts
  always_comb
  begin
    home_raw       = {8{pos_ff >= SWITCH_AT}};
    index_raw      = {8{pos_ff[5:0] == 6'h00}};
    prof_stopped   = !prof_move && coast_ff == 0 && !(prof_goto && pos_ff != prof_target);
    prof_at_target = prof_goto && pos_ff == prof_target;
    for (int k = 0; k < 8; k++)
    begin
      main_pos[k] = pos_ff + (32'(k) << 20);
      aux_pos[k]  = ~main_pos[k];
    end
  end
endmodule // hspl_axis_model
`default_nettype wire

// *** test/hspl_top_test.sv ***
// Self-checking testbench for the homing sequencer and position latch
`timescale 1ns/1ps
`default_nettype none
module hspl_top_test;
  import hspl_pkg::*;
  logic             hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0]      haddr, hwdata, hrdata, d;
  logic [1:0]       htrans;
  logic [2:0]       hsize;
  logic [7:0]       home_raw, index_raw, fb_home, fb_index;
  logic [11:0]      gp_in;
  logic [7:0][31:0] main_pos, aux_pos;
  logic             stopped, at_target, move, dir, halt, go, ld, preset_en;
  logic [2:0]       axis;
  logic [31:0]      speed, target, ld_val, preset_val;
  int               err_total, comparisons, cyc, halt_cnt, base;
  // ==========================================================
  // Design, axis model and clock
  hspl_top DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata_ff(hrdata), .hreadyout_ff(hreadyout), .hresp_ff(hresp), .home_raw(home_raw),
    .index_raw(index_raw), .fb_home(fb_home), .fb_index(fb_index), .gp_in(gp_in),
    .main_pos(main_pos), .aux_pos(aux_pos), .prof_stopped(stopped),
    .prof_at_target(at_target), .prof_axis_ff(axis), .prof_move_ff(move),
    .prof_dir_ff(dir), .prof_speed_ff(speed), .prof_halt_ff(halt), .prof_goto_ff(go),
    .prof_target_ff(target), .enc_load_ff(ld), .enc_load_val_ff(ld_val));
  hspl_axis_model partner (.hclk(hclk), .hresetn(hresetn), .preset_en(preset_en),
    .preset_val(preset_val), .prof_move(move), .prof_dir(dir), .prof_halt(halt),
    .prof_goto(go), .prof_target(target), .enc_load(ld), .enc_load_val(ld_val),
    .home_raw(home_raw), .index_raw(index_raw), .main_pos(main_pos), .aux_pos(aux_pos),
    .prof_stopped(stopped), .prof_at_target(at_target));
  initial
  begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end
  // Cycle ceiling and stop-pulse counter
  always @(posedge hclk)
  begin
    cyc++;
    if (halt === 1'b1)
      halt_cnt++;
    if (cyc == 30000)
    begin
      err_total++;
      results();
    end
  end
  // ==========================================================
  // Bus, compare and helper tasks
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {24'h00_0000, a};
    htrans <= 2'h2;
    hwrite <= wr;
    hsize  <= 3'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wr32(input logic [7:0] a, input logic [31:0] v);
    logic [31:0] x;
    ahb(1'b1, a, v, x);
  endtask
  task automatic rd32(input logic [7:0] a);
    ahb(1'b0, a, 32'h0000_0000, d);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic preset(input logic [31:0] v);
    @(posedge hclk);
    preset_en  <= 1'b1;
    preset_val <= v;
    @(posedge hclk);
    preset_en  <= 1'b0;
  endtask
  task automatic start(input logic [1:0] cmd);
    base = halt_cnt;
    wr32(CTRL_OFS, {26'h0, cmd, 4'h0});
    @(negedge hclk);
  endtask
  task automatic wait_idle();
    do rd32(STAT_OFS); while (d[0] !== 1'b0);
  endtask
  task automatic settle();
    repeat (4) @(posedge hclk);
  endtask
  task automatic results();
    $display("comparisons=%0d err_total=%0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // ==========================================================
  // Test sequence
  initial
  begin
    hresetn = 1'b0; hsel = 1'b0; haddr = '0; htrans = '0; hwrite = 1'b0; hsize = '0;
    hwdata = '0; fb_home = 8'hFF; fb_index = 8'h00; gp_in = 12'hFFF;
    preset_en = 1'b0; preset_val = '0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    rd32(POL_OFS);   chk(d, {24'h0, POL_RST});
    rd32(HVEL_OFS);  chk(d, HVEL_RST);
    rd32(STAT_OFS);  chk(d, 32'h0000_0000);
    rd32(8'h80);     chk(d, 32'h0000_0000);
    chk({31'h0, hresp}, 32'h0000_0000);
    $display("test reset values done");
    preset(32'h0000_00C8);
    wr32(POL_OFS, 32'h0000_00A5);
    rd32(STAT_OFS);  chk({24'h0, d[15:8]}, 32'h0000_005A);
    wr32(CAPCFG_OFS, 32'h0001_0000);
    fb_home <= 8'hFE;
    rd32(STAT_OFS);  chk({30'h0, d[9:8]}, 32'h0000_0003);
    wr32(POL_OFS, 32'h0000_0000);
    wr32(CAPCFG_OFS, 32'h0000_0000);
    $display("test polarity and status done");
    wr32(SLEW_OFS, 32'h0000_1234);
    wr32(HVEL_OFS, 32'h0000_0567);
    preset(32'h0000_0032);
    start(CMD_EDGE);
    chk({30'h0, dir, move}, 32'h0000_0001);
    chk(speed, 32'h0000_1234);
    wait_idle();
    chk({31'h0, d[1]}, 32'h0000_0001);
    chk({31'h0, main_pos[0] >= 32'h64 && main_pos[0] <= 32'h6A}, 32'h1);
    $display("test edge search done");
    preset(32'h0000_00C8);
    start(CMD_HOME);
    chk({30'h0, dir, move}, 32'h0000_0003);
    while (!(move === 1'b1 && dir === 1'b0)) @(negedge hclk);
    chk(speed, 32'h0000_0567);
    wait_idle();
    chk(32'(halt_cnt - base), 32'h0000_0000);
    chk(main_pos[0], 32'h0000_0000);
    chk({31'h0, d[1]}, 32'h0000_0001);
    preset(32'h0000_0032);
    start(CMD_HOME);
    chk({30'h0, dir, move}, 32'h0000_0001);
    wait_idle();
    chk(32'(halt_cnt - base), 32'h0000_0001);
    chk(main_pos[0], 32'h0000_0000);
    $display("test full home done");
    preset(32'h0000_0050);
    start(CMD_INDEX);
    chk({30'h0, dir, move}, 32'h0000_0001);
    chk(speed, 32'h0000_0567);
    wait_idle();
    chk(main_pos[0], 32'h0000_0000);
    chk({31'h0, d[1]}, 32'h0000_0001);
    $display("test index search done");
    preset(32'h0000_0300);
    wr32(ARM_OFS, 32'h0000_0011);
    rd32(STAT_OFS);  chk({16'h0, d[31:16]}, 32'h0000_1100);
    gp_in <= 12'hFFE;
    settle();
    rd32(STAT_OFS);  chk({16'h0, d[31:16]}, 32'h0000_1001);
    rd32({CAPPOS_PAGE, 3'h0, 2'h0}); chk(d, 32'h0000_0300);
    gp_in <= 12'hFFF;
    preset(32'h0000_0400);
    gp_in <= 12'hFFE;
    settle();
    rd32({CAPPOS_PAGE, 3'h0, 2'h0}); chk(d, 32'h0000_0300);
    wr32(CAPCFG_OFS, 32'h0000_1000);
    gp_in <= 12'hEFE;
    settle();
    rd32({CAPPOS_PAGE, 3'h4, 2'h0}); chk(d, 32'hFFBF_FBFF);
    wr32(CAPCFG_OFS, 32'h0000_0002);
    preset(32'h0000_0440);
    wr32(ARM_OFS, 32'h0000_0002);
    preset(32'h0000_0441);
    settle();
    rd32({CAPPOS_PAGE, 3'h1, 2'h0}); chk(d, 32'h0010_0441);
    wr32(CAPCFG_OFS, 32'h0004_0004);
    preset(32'h0000_0480);
    wr32(ARM_OFS, 32'h0000_0004);
    preset(32'h0000_0481);
    settle();
    rd32(STAT_OFS);  chk({31'h0, d[18]}, 32'h0000_0000);
    fb_index <= 8'h04;
    settle();
    fb_index <= 8'h00;
    settle();
    rd32({CAPPOS_PAGE, 3'h2, 2'h0}); chk(d, 32'h0020_0481);
    $display("test position capture done");
    results();
  end
endmodule // hspl_top_test
`default_nettype wire
